// ===== hdl/adc_ctl_pkg.sv
package adc_ctl_pkg;
  // ==========================================================
  // frame layout, counted in serial clock edges after the start bit
  localparam int RES_BITS = 12;
  localparam int CODE_STEPS = 4096;
  localparam int CNT_W = 5;
  localparam logic [4:0] RISE_SGL = 5'h05;
  localparam logic [4:0] RISE_LAST = 5'h07;
  localparam logic [4:0] FALL_HOLD = 5'h07;
  localparam logic [4:0] FALL_MSB = 5'h09;
  localparam logic [4:0] FALL_LSB = 5'h14;
  localparam logic [4:0] FALL_TAIL = 5'h16;
  localparam logic [4:0] FALL_END = 5'h17;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [1:0] PD_RST = 2'h3;
  localparam int CH_N = 8;
  localparam int SHARED_NEG = 8;

  // ==========================================================
  // frame phases
  typedef enum logic [2:0]
  {
    PH_IDLE = 3'b001,
    PH_CTRL = 3'b010,
    PH_CONV = 3'b100
  } phase_t;
endpackage : adc_ctl_pkg

// ===== hdl/mux_decode.sv
`timescale 1ns/1ps
module mux_decode
  import adc_ctl_pkg::*;
(
  input wire logic [2:0] channel_select,
  input wire logic single_diff_select,
  output logic [CH_N-1:0] pos_sel,
  output logic [CH_N:0] neg_sel
);
  // ==========================================================
  // a2 is the low bit of the channel number
  always_comb
  begin
    pos_sel = '0;
    neg_sel = '0;
    pos_sel[{channel_select[1:0], channel_select[2]}] = 1'b1;
    if (single_diff_select)
      neg_sel[SHARED_NEG] = 1'b1; // [RQ1]
    else
      neg_sel[{channel_select[1:0], ~channel_select[2]}] = 1'b1; // [RQ2]
  end
endmodule : mux_decode

// ===== hdl/serial_adc_mux_control.sv
`timescale 1ns/1ps
// Contract
// [RQ1] single-ended: selected channel positive, shared negative pin negative
// [RQ2] differential: pairs 0/1..6/7, a2 high swaps polarity
// [RQ3] channel and mode bits come only from the serial data input
// [RQ4] host transfers in groups of eight serial clocks; the testbench host sends lead plus nclk clocks, not rounded to eight
// [RQ5] host gives three transfers, 24 serial clocks per conversion
// [RQ6] control byte shifts in during the first eight serial clocks
// [RQ7] once mode bits known, mux switches and acquisition starts
// [RQ8] three clocks later byte complete: hold and begin conversion
// [RQ9] conversion spans twelve clocks, last bit out on thirteenth
// [RQ10] last three clocks drive output low and are otherwise ignored
// [RQ11] 12-bit result, one step is reference over 4096
// [RQ12] result shifted out msb first, one bit per serial clock
// [RQ13] input sampled on rising serial clock while chip select low
// [RQ14] output changes on falling edges, disabled while chip select high
// [RQ15] control byte msb first: start, channel x3, unused, mode, power-down x2
// [RQ16] input ignored until a high start bit appears
module serial_adc_mux_control
  import adc_ctl_pkg::*;
#(
  parameter int RES_W = RES_BITS
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic serial_clock,
  input wire logic sdi,
  input wire logic [RES_W-1:0] conv_code,
  output logic sdo,
  output logic sdo_oe,
  output logic [CH_N-1:0] pos_sel,
  output logic [CH_N:0] neg_sel,
  output logic sample_acquire,
  output logic sample_hold,
  output logic [1:0] power_down_mode
);
  // ==========================================================
  // state
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic ck_s1;
    logic ck_s2;
    logic ck_d;
    logic di_s1;
    logic di_s2;
    phase_t ph;
    logic [CNT_W-1:0] rcnt;
    logic [CNT_W-1:0] fcnt;
    logic [5:0] ctrl;
    logic [2:0] chan;
    logic sgl;
    logic [1:0] pd;
    logic acq;
    logic hold;
    logic [RES_W-1:0] res;
    logic sdo;
    logic oe;
    logic [CH_N-1:0] pos;
    logic [CH_N:0] neg;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic rise;
  logic fall;
  logic [CH_N-1:0] dec_pos;
  logic [CH_N:0] dec_neg;

  // decode from the held channel bits and the mode bit just arriving so the mux moves on the same edge
  mux_decode u_dec
  (
    .channel_select(st_r.ctrl[3:1]),
    .single_diff_select(st_r.di_s2),
    .pos_sel(dec_pos),
    .neg_sel(dec_neg)
  );

  // ==========================================================
  // edge detect on the oversampled serial clock
  // link clock is slow (128 ns), so a 3-stage sample sees every edge
  assign rise = st_r.ck_s2 & ~st_r.ck_d;
  assign fall = ~st_r.ck_s2 & st_r.ck_d;

  // ==========================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.cs_s1 = cs_n;
    st_nxt.cs_s2 = st_r.cs_s1;
    st_nxt.ck_s1 = serial_clock;
    st_nxt.ck_s2 = st_r.ck_s1;
    st_nxt.ck_d = st_r.ck_s2;
    st_nxt.di_s1 = sdi;
    st_nxt.di_s2 = st_r.di_s1;
    if (st_r.cs_s2)
    begin
      // deselect aborts any frame; output released
      st_nxt.ph = PH_IDLE;
      st_nxt.rcnt = '0;
      st_nxt.fcnt = '0;
      st_nxt.acq = 1'b0;
      st_nxt.hold = 1'b0;
      st_nxt.sdo = 1'b0;
      st_nxt.oe = 1'b0; // [RQ14]
    end
    else
    begin
      st_nxt.oe = 1'b1;
      case (st_r.ph)
        PH_IDLE:
        begin
          st_nxt.sdo = 1'b0;
          if (rise && st_r.di_s2) // [RQ13] [RQ16]
          begin
            st_nxt.ph = PH_CTRL;
            st_nxt.rcnt = 5'h01;
            st_nxt.fcnt = '0;
          end
        end
        PH_CTRL:
        begin
          if (rise)
          begin
            st_nxt.ctrl = {st_r.ctrl[4:0], st_r.di_s2}; // [RQ3] [RQ6] [RQ15]
            st_nxt.rcnt = st_r.rcnt + 5'h01;
            if (st_r.rcnt == RISE_SGL)
            begin
              st_nxt.chan = st_r.ctrl[3:1];
              st_nxt.sgl = st_r.di_s2;
              st_nxt.pos = dec_pos; // [RQ1] [RQ2]
              st_nxt.neg = dec_neg;
              st_nxt.acq = 1'b1; // [RQ7]
            end
            if (st_r.rcnt == RISE_LAST)
              st_nxt.pd = {st_r.ctrl[0], st_r.di_s2}; // [RQ15]
          end
          if (fall)
          begin
            st_nxt.fcnt = st_r.fcnt + 5'h01;
            if (st_r.fcnt == FALL_HOLD)
            begin
              // twelve-bit code, one step is reference / CODE_STEPS
              st_nxt.res = conv_code; // [RQ11]
              st_nxt.acq = 1'b0;
              st_nxt.hold = 1'b1; // [RQ8]
              st_nxt.ph = PH_CONV;
            end
          end
        end
        PH_CONV:
        begin
          if (fall)
          begin
            st_nxt.fcnt = st_r.fcnt + 5'h01;
            if (st_r.fcnt >= FALL_MSB && st_r.fcnt <= FALL_LSB)
            begin
              st_nxt.sdo = st_r.res[RES_W-1]; // [RQ9] [RQ12]
              st_nxt.res = {st_r.res[RES_W-2:0], 1'b0};
            end
            else
              st_nxt.sdo = 1'b0; // [RQ10]
            if (st_r.fcnt == FALL_LSB + 5'h01)
              st_nxt.hold = 1'b0;
            if (st_r.fcnt == FALL_END)
              st_nxt.ph = PH_IDLE;
          end
        end
        default:
        begin
          st_nxt.ph = PH_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.cs_s1 <= 1'b1;
      st_r.cs_s2 <= 1'b1;
      st_r.ph <= PH_IDLE;
      st_r.ctrl <= CTRL_RST;
      st_r.pd <= PD_RST;
      st_r.sgl <= 1'b1;
      st_r.pos <= {{(CH_N-1){1'b0}}, 1'b1};
      st_r.neg <= {1'b1, {CH_N{1'b0}}};
    end
    else
      st_r <= st_nxt;
  end

  assign sdo = st_r.sdo;
  assign sdo_oe = st_r.oe;
  assign pos_sel = st_r.pos;
  assign neg_sel = st_r.neg;
  assign sample_acquire = st_r.acq;
  assign sample_hold = st_r.hold;
  assign power_down_mode = st_r.pd;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_oe_off;
    st_r.cs_s2 |=> !sdo_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output enabled while deselected"); // [RQ14]

  property p_sdo_on_fall;
    $changed(sdo) && !st_r.cs_s2 && !$past(st_r.cs_s2) |-> $past(fall);
  endproperty
  a_sdo_on_fall: assert property (p_sdo_on_fall) else $error("sdo moved off a fall"); // [RQ14]

  property p_single;
    $rose(sample_acquire) && st_r.sgl |-> neg_sel[SHARED_NEG] && $onehot(pos_sel);
  endproperty
  a_single: assert property (p_single) else $error("single-ended mux wrong"); // [RQ1]

  property p_diff;
    $rose(sample_acquire) && !st_r.sgl |->
      !neg_sel[SHARED_NEG] && ((neg_sel[CH_N-1:0] ^ pos_sel) != '0) && $onehot(neg_sel);
  endproperty
  a_diff: assert property (p_diff) else $error("differential mux wrong"); // [RQ2]

  // positive leg must follow the latched channel bits, a2 being the low channel bit
  property p_chan;
    $rose(sample_acquire) |-> pos_sel[{st_r.chan[1:0], st_r.chan[2]}];
  endproperty
  a_chan: assert property (p_chan) else $error("mux not set from channel bits"); // [RQ3]

  property p_ignore;
    st_r.ph == PH_IDLE && !st_r.cs_s2 && rise && !st_r.di_s2 |=> st_r.ph == PH_IDLE;
  endproperty
  a_ignore: assert property (p_ignore) else $error("frame began without start bit"); // [RQ16]

  property p_acq;
    st_r.ph == PH_CTRL && !st_r.cs_s2 && rise && st_r.rcnt == RISE_SGL |=> sample_acquire;
  endproperty
  a_acq: assert property (p_acq) else $error("acquisition not entered"); // [RQ7]

  property p_hold;
    $fell(sample_acquire) && !$past(st_r.cs_s2) |-> sample_hold && st_r.ph == PH_CONV;
  endproperty
  a_hold: assert property (p_hold) else $error("hold did not follow acquisition"); // [RQ8]

  property p_msb;
    st_r.ph == PH_CONV && fall && !st_r.cs_s2 && st_r.fcnt == FALL_MSB
      |=> sdo == $past(st_r.res[RES_W-1]);
  endproperty
  a_msb: assert property (p_msb) else $error("msb not first"); // [RQ12]

  property p_tail;
    st_r.ph == PH_CONV && st_r.fcnt >= FALL_TAIL |-> !sdo;
  endproperty
  a_tail: assert property (p_tail) else $error("tail clocks not low"); // [RQ10]
endmodule : serial_adc_mux_control

// ===== testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire logic sdo_line,
  input wire logic sdo_oe,
  input wire logic sample_acquire,
  input wire logic sample_hold,
  output logic cs_n,
  output logic serial_clock,
  output logic sdi
);
  // ==========================================================
  // host serial port, clock stands low outside frames
  logic [23:0] rx;
  logic oe_seen;
  logic acq_seen;
  logic hold_seen;

  initial
  begin
    cs_n = 1'b1;
    serial_clock = 1'b0;
    sdi = 1'b0;
  end

  task automatic half();
    repeat (8) @(negedge clk);
  endtask : half

  // lead zero clocks come before the start bit
  task automatic frame(input logic [7:0] ctrl, input int lead, input int nclk);
    rx = 24'h000000;
    cs_n = 1'b0;
    half();
    for (int i = 0; i < lead + nclk; i++)
    begin
      sdi = (i >= lead && i < lead + 8) ? ctrl[7 - (i - lead)] : 1'b0;
      half();
      if (i >= lead) rx = {rx[22:0], sdo_line};
      if (i == lead) oe_seen = sdo_oe;
      if (i == lead + 7) acq_seen = sample_acquire;
      if (i == lead + 9) hold_seen = sample_hold;
      serial_clock = 1'b1;
      half();
      serial_clock = 1'b0;
    end
    half();
    // lead plus nclk clocks in all, not rounded to groups of eight
    cs_n = 1'b1;
    sdi = ~sdi;
    half();
  endtask : frame
endmodule : host_model

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench
  import adc_ctl_pkg::*;
;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic rst_n;
  logic cs_n, serial_clock, sdi, sdo, sdo_oe, acq, hold;
  logic [RES_BITS-1:0] conv_code;
  logic [CH_N-1:0] pos_sel, epos;
  logic [CH_N:0] neg_sel, eneg;
  logic [1:0] pd;
  logic [7:0] ctrl;
  logic [2:0] ch;
  logic line_last = 1'b0;
  logic sdo_line;
  int err_total = 0;
  int total_checks = 0;

  initial
  begin
    forever #4 clk = ~clk;
  end

  // undriven line toggles, so a stale bit never reads as valid
  always_ff @(posedge clk) line_last <= sdo_line;
  assign sdo_line = sdo_oe ? sdo : ~line_last;

  serial_adc_mux_control serial_adc_mux_control_inst (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
    .serial_clock(serial_clock), .sdi(sdi), .conv_code(conv_code), .sdo(sdo), .sdo_oe(sdo_oe),
    .pos_sel(pos_sel), .neg_sel(neg_sel), .sample_acquire(acq), .sample_hold(hold),
    .power_down_mode(pd));
  host_model host_model_inst (.clk(clk), .sdo_line(sdo_line), .sdo_oe(sdo_oe),
    .sample_acquire(acq), .sample_hold(hold), .cs_n(cs_n), .serial_clock(serial_clock),
    .sdi(sdi));

  // ==========================================================
  // checking and verdict
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  initial
  begin
    #300000;
    err_total++;
    summarize();
  end

  // ==========================================================
  // tests
  initial
  begin
    rst_n = 1'b0;
    conv_code = 12'h000;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check("pos_rst", 16'(pos_sel), 16'h0001);
    check("neg_rst", 16'(neg_sel), 16'h0100);
    check("oe_rst", 16'(sdo_oe), 16'h0000);
    check("pd_rst", 16'(pd), 16'(PD_RST));
    $display("test reset done");
    // every channel code, both modes, all power-down codes
    for (int i = 0; i < 16; i++)
    begin
      ctrl = {1'b1, i[2:0], 1'b0, i[3], i[1:0]};
      conv_code = 12'ha5c ^ 12'(i * 273);
      host_model_inst.frame(ctrl, i % 3, 24);
      ch = {ctrl[5], ctrl[4], ctrl[6]};
      epos = ctrl[2] ? 8'h01 << ch : 8'h01 << {ctrl[5:4], ctrl[6]};
      eneg = ctrl[2] ? 9'h100 : 9'h001 << {ctrl[5:4], ~ctrl[6]};
      check("pos_sel", 16'(pos_sel), 16'(epos));
      check("neg_sel", 16'(neg_sel), 16'(eneg));
      check("pd", 16'(pd), 16'(ctrl[1:0]));
      check("result", 16'(host_model_inst.rx[13:2]), 16'(conv_code));
      check("tail", 16'({host_model_inst.rx[14], host_model_inst.rx[1:0]}), 16'h0000);
      check("oe_on", 16'(host_model_inst.oe_seen), 16'h0001);
      check("acq", 16'(host_model_inst.acq_seen), 16'h0001);
      check("hold", 16'(host_model_inst.hold_seen), 16'h0001);
      check("hold_end", 16'({hold, sdo_oe}), 16'h0000);
    end
    $display("test sweep done");
    // abort before the mode bit keeps the old mux
    host_model_inst.frame(8'hf0, 0, 4);
    check("abort_pos", 16'(pos_sel), 16'(epos));
    check("abort_oe", 16'(sdo_oe), 16'h0000);
    conv_code = 12'h801;
    host_model_inst.frame(8'hb7, 0, 24);
    check("pos_after", 16'(pos_sel), 16'h0040);
    check("res_after", 16'(host_model_inst.rx[13:2]), 16'h0801);
    $display("test abort done");
    summarize();
  end
endmodule : testbench
